// ===== inc/swl_params.svh
`ifndef SWL_PARAMS_SVH
`define SWL_PARAMS_SVH

// Address table
`define SWL_TABLE_ENTRIES 1024
`define SWL_IDX_W         10
`define SWL_LAST_IDX      10'h3ff
`define SWL_STATIC_COUNT  4
`define SWL_VLAN_COUNT    16

// Ports
`define SWL_PORTS         5

// Frame length limits in bytes
`define SWL_MIN_LEN       12'd64
`define SWL_MAX_LEN       12'd1536

// Shared frame memory
`define SWL_BUF_COUNT     10'd512
`define SWL_BUF_BYTES     128
`define SWL_BUF_SHIFT     7
`define SWL_BUF_ROUND     13'd127

// Aging: period and tolerance in seconds, clock rate in Hz
`define SWL_AGE_PERIOD_S  64'd300
`define SWL_AGE_TOL_S     64'd75
`define SWL_AGE_TICKS     3'd4
`define SWL_CLK_HZ        64'd100000000

// Multicast flag position in a station address
`define SWL_MCAST_BIT     40

`endif

// ===== inc/swl_pkg.sv
package swl_pkg;
   typedef logic [2:0]  swl_port_t;
   typedef logic [4:0]  swl_mask_t;
   typedef logic [47:0] swl_mac_t;

   typedef struct packed {
      logic      valid;
      swl_mac_t  mac;
      swl_port_t port;
      logic [2:0] stamp;
   } swl_entry_s;

   typedef struct packed {
      logic      valid;
      swl_mac_t  mac;
      swl_mask_t mask;
   } swl_static_s;

   typedef struct packed {
      logic                  aging_en;
      swl_mask_t             stp_fwd_mask;
      swl_mask_t             auth_mask;
      logic                  mirror_en;
      swl_port_t             mirror_port;
      swl_mask_t             mirror_rx_mask;
      swl_port_t             host_port;
      swl_mask_t [15:0]      vlan_mask;
      swl_static_s [3:0]     static_tab;
   } swl_cfg_s;

   typedef struct packed {
      swl_port_t   ingress;
      swl_mac_t    destination_station_address;
      swl_mac_t    source_station_address;
      logic [11:0] vid;
      logic [11:0] len;
      logic        err_fcs;
      logic        err_framing;
      logic        err_align;
      logic        is_pause;
      logic [15:0] pause_quanta;
      logic        is_igmp;
      logic        access_list_hit;
      swl_mask_t   access_list_filter;
   } swl_frame_s;

   typedef struct packed {
      swl_port_t ingress;
      swl_mask_t final_port_mask;
      logic [9:0] bufs;
   } swl_fwd_s;

   typedef struct packed {
      swl_port_t   port;
      logic [15:0] quanta;
   } swl_pause_s;

   typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_DECIDE, ST_OUT} swl_state_e;

   typedef struct packed {
      swl_state_e               st;
      swl_entry_s [1023:0]      table_e;
      logic [9:0]               idx;
      logic [9:0]               age_ptr;
      swl_frame_s               frm;
      logic                     sa_hit;
      logic [9:0]               sa_idx;
      logic                     da_hit;
      logic [9:0]               da_idx;
      logic                     free_hit;
      logic [9:0]               free_idx;
      logic [2:0]               now;
      logic [35:0]              tick_cnt;
      logic [9:0]               used_bufs;
      logic                     fwd_valid;
      swl_fwd_s                 fwd;
      logic                     pause_valid;
      swl_pause_s               pause;
   } swl_state_s;
endpackage

// ===== verilog/swl_core.sv
`include "swl_params.svh"

module swl_core #(
   parameter logic [35:0] AGE_TICK_CYC =
      36'((`SWL_AGE_PERIOD_S / 64'(`SWL_AGE_TICKS)) * `SWL_CLK_HZ)
) (
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   input  wire swl_pkg::swl_cfg_s cfg,
   input  wire logic              frm_valid,
   output logic                   frm_ready,
   input  wire swl_pkg::swl_frame_s frm,
   output logic                   fwd_valid,
   input  wire logic              fwd_ready,
   output swl_pkg::swl_fwd_s      fwd,
   output logic                   pause_valid,
   output swl_pkg::swl_pause_s    pause,
   input  wire logic              rel_valid,
   input  wire logic [9:0]        rel_count
);
   import swl_pkg::*;

   swl_state_s s_reg;
   swl_state_s s_next;

   function automatic swl_mask_t port_bit(input swl_port_t p);
      port_bit = swl_mask_t'(5'h01 << p);
   endfunction

   function automatic logic is_stale(input swl_entry_s e, input logic [2:0] now);
      is_stale = e.valid && (3'(now - e.stamp) >= `SWL_AGE_TICKS);
   endfunction

   function automatic logic frame_good(input swl_frame_s f);
      frame_good = !(f.err_fcs || f.err_framing || f.err_align) &&
                   (f.len >= `SWL_MIN_LEN) && (f.len <= `SWL_MAX_LEN);
   endfunction

   // Two-stage destination resolution
   function automatic swl_mask_t resolve(input swl_frame_s f, input swl_cfg_s c,
                                         input logic da_hit, input swl_port_t da_port);
      swl_mask_t vmask;
      swl_mask_t m;
      logic      st_hit;
      vmask  = c.vlan_mask[f.vid[3:0]];
      m      = 5'h00;
      st_hit = 1'b0;
      for (int i = 0; i < `SWL_STATIC_COUNT; i++) begin
         if (!st_hit && c.static_tab[i].valid &&
             c.static_tab[i].mac == f.destination_station_address) begin
            st_hit = 1'b1;
            m      = c.static_tab[i].mask;
         end
      end
      if (!st_hit) begin
         if (f.destination_station_address[`SWL_MCAST_BIT]) begin
            m = vmask;
         end else if (da_hit) begin
            m = (da_port == f.ingress) ? 5'h00 : port_bit(da_port);
         end else begin
            m = vmask;
         end
      end
      m = m & ~port_bit(f.ingress);
      m = m & c.stp_fwd_mask;
      if (f.is_igmp) begin
         m = port_bit(c.host_port) & ~port_bit(f.ingress);
      end
      if (c.mirror_en && c.mirror_rx_mask[f.ingress] && m != 5'h00) begin
         m = m | port_bit(c.mirror_port);
      end
      m = m & vmask;
      if (!c.auth_mask[f.ingress]) begin
         m = 5'h00;
      end else if (f.access_list_hit) begin
         m = f.access_list_filter;
      end
      resolve = m;
   endfunction

   swl_mask_t  dec_mask;
   logic       dec_good;
   logic [9:0] dec_bufs;
   logic [9:0] learn_idx;
   logic       learn_new;
   logic [9:0] free_now;

   assign dec_good  = frame_good(s_reg.frm);
   assign dec_mask  = resolve(s_reg.frm, cfg, s_reg.da_hit,
                              s_reg.table_e[s_reg.da_idx].port);
   assign dec_bufs  = 10'(({1'b0, s_reg.frm.len} + `SWL_BUF_ROUND) >> `SWL_BUF_SHIFT);
   assign learn_idx = s_reg.free_hit ? s_reg.free_idx : `SWL_LAST_IDX;
   assign learn_new = (s_reg.st == ST_DECIDE) && !s_reg.sa_hit && dec_good &&
                      !s_reg.frm.is_pause;
   assign free_now  = `SWL_BUF_COUNT - s_reg.used_bufs;

   always_comb begin
      s_next             = s_reg;
      s_next.pause_valid = 1'b0;
      if (s_reg.tick_cnt == AGE_TICK_CYC - 36'd1) begin
         s_next.tick_cnt = 36'd0;
         s_next.now      = 3'(s_reg.now + 3'd1);
      end else begin
         s_next.tick_cnt = 36'(s_reg.tick_cnt + 36'd1);
      end
      if (rel_valid) begin
         s_next.used_bufs = (rel_count > s_reg.used_bufs) ? 10'd0 :
                            10'(s_reg.used_bufs - rel_count);
      end
      case (s_reg.st)
         ST_IDLE: begin
            if (frm_valid) begin
               s_next.frm      = frm;
               s_next.idx      = 10'd0;
               s_next.sa_hit   = 1'b0;
               s_next.da_hit   = 1'b0;
               s_next.free_hit = 1'b0;
               s_next.st       = ST_SCAN;
            end else begin
               if (cfg.aging_en && is_stale(s_reg.table_e[s_reg.age_ptr], s_reg.now)) begin
                  s_next.table_e[s_reg.age_ptr].valid = 1'b0;
               end
               s_next.age_ptr = 10'(s_reg.age_ptr + 10'd1);
            end
         end
         ST_SCAN: begin
            if (s_reg.table_e[s_reg.idx].valid) begin
               if (!s_reg.sa_hit &&
                   s_reg.table_e[s_reg.idx].mac == s_reg.frm.source_station_address) begin
                  s_next.sa_hit = 1'b1;
                  s_next.sa_idx = s_reg.idx;
               end
               if (!s_reg.da_hit && s_reg.table_e[s_reg.idx].mac ==
                   s_reg.frm.destination_station_address) begin
                  s_next.da_hit = 1'b1;
                  s_next.da_idx = s_reg.idx;
               end
            end else if (!s_reg.free_hit) begin
               s_next.free_hit = 1'b1;
               s_next.free_idx = s_reg.idx;
            end
            if (s_reg.idx == `SWL_LAST_IDX) begin
               s_next.st = ST_DECIDE;
            end else begin
               s_next.idx = 10'(s_reg.idx + 10'd1);
            end
         end
         ST_DECIDE: begin
            s_next.st = ST_IDLE;
            if (s_reg.sa_hit) begin
               s_next.table_e[s_reg.sa_idx].stamp = s_reg.now;
               if (dec_good) begin
                  s_next.table_e[s_reg.sa_idx].port = s_reg.frm.ingress;
               end
            end else if (learn_new) begin
               s_next.table_e[learn_idx].valid = 1'b1;
               s_next.table_e[learn_idx].mac   = s_reg.frm.source_station_address;
               s_next.table_e[learn_idx].port  = s_reg.frm.ingress;
               s_next.table_e[learn_idx].stamp = s_reg.now;
            end
            if (s_reg.frm.is_pause) begin
               s_next.pause_valid  = 1'b1;
               s_next.pause.port   = s_reg.frm.ingress;
               s_next.pause.quanta = s_reg.frm.pause_quanta;
            end else if (dec_good && dec_mask != 5'h00 && dec_bufs <= free_now) begin
               s_next.fwd_valid           = 1'b1;
               s_next.fwd.ingress         = s_reg.frm.ingress;
               s_next.fwd.final_port_mask = dec_mask;
               s_next.fwd.bufs            = dec_bufs;
               s_next.used_bufs           = 10'(s_next.used_bufs + dec_bufs);
               s_next.st                  = ST_OUT;
            end
         end
         ST_OUT: begin
            if (fwd_ready) begin
               s_next.fwd_valid = 1'b0;
               s_next.st        = ST_IDLE;
            end
         end
         default: begin
            s_next.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign frm_ready   = (s_reg.st == ST_IDLE);
   assign fwd_valid   = s_reg.fwd_valid;
   assign fwd         = s_reg.fwd;
   assign pause_valid = s_reg.pause_valid;
   assign pause       = s_reg.pause;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   a_fwd_no_error: assert property (fwd_valid |-> !(s_reg.frm.err_fcs ||
      s_reg.frm.err_framing || s_reg.frm.err_align))
      else $error("errored frame forwarded");
   a_fwd_legal_len: assert property (fwd_valid |->
      (s_reg.frm.len >= `SWL_MIN_LEN && s_reg.frm.len <= `SWL_MAX_LEN))
      else $error("illegal length frame forwarded");
   a_pause_not_fwd: assert property ((s_reg.st == ST_DECIDE && s_reg.frm.is_pause)
      |=> pause_valid && !fwd_valid ##1 !pause_valid)
      else $error("pause frame not consumed");
   a_local_dropped: assert property (fwd_valid |->
      !fwd.final_port_mask[fwd.ingress] || s_reg.frm.access_list_hit)
      else $error("frame sent back to ingress");
   a_acl_override: assert property ((fwd_valid && s_reg.frm.access_list_hit)
      |-> fwd.final_port_mask == s_reg.frm.access_list_filter)
      else $error("access list result not applied");
   a_buf_bound: assert property (s_reg.used_bufs <= `SWL_BUF_COUNT)
      else $error("buffer pool overcommitted");
   a_scan_done: assert property ((s_reg.st == ST_SCAN && s_reg.idx == `SWL_LAST_IDX)
      |=> s_reg.st == ST_DECIDE)
      else $error("scan did not end at last entry");
   a_learn_entry: assert property (learn_new |=>
      s_reg.table_e[$past(learn_idx)].valid &&
      s_reg.table_e[$past(learn_idx)].mac == $past(s_reg.frm.source_station_address) &&
      s_reg.table_e[$past(learn_idx)].port == $past(s_reg.frm.ingress))
      else $error("learned entry wrong");
   a_age_remove: assert property ((s_reg.st == ST_IDLE && !frm_valid && cfg.aging_en &&
      is_stale(s_reg.table_e[s_reg.age_ptr], s_reg.now))
      |=> !s_reg.table_e[$past(s_reg.age_ptr)].valid)
      else $error("stale entry not removed");
   a_age_off_keep: assert property ((s_reg.st == ST_IDLE && !cfg.aging_en &&
      s_reg.table_e[s_reg.age_ptr].valid) |=> s_reg.table_e[$past(s_reg.age_ptr)].valid)
      else $error("entry expired with aging off");
   a_fwd_hold: assert property (fwd_valid && !fwd_ready |=>
      fwd_valid && $stable(fwd))
      else $error("forward output changed before accept");
   a_auth_block: assert property (fwd_valid |-> cfg.auth_mask[fwd.ingress])
      else $error("frame forwarded from unauthorised port");
   a_stamp_fresh: assert property ((s_reg.st == ST_DECIDE && s_reg.sa_hit) |=>
      s_reg.table_e[$past(s_reg.sa_idx)].stamp == $past(s_reg.now))
      else $error("time stamp not refreshed");
   a_migrate_port: assert property ((s_reg.st == ST_DECIDE && s_reg.sa_hit &&
      dec_good) |=> s_reg.table_e[$past(s_reg.sa_idx)].port == $past(s_reg.frm.ingress))
      else $error("moved station keeps old port");
   a_evict_last: assert property ((learn_new && !s_reg.free_hit) |=>
      s_reg.table_e[`SWL_LAST_IDX].mac == $past(s_reg.frm.source_station_address))
      else $error("full table did not reuse last entry");
   a_fwd_nonzero: assert property (fwd_valid |->
      fwd.final_port_mask != 5'h00 && fwd.bufs != 10'h000)
      else $error("empty forward descriptor");

   c_learn: cover property (learn_new && !s_reg.free_hit);
   c_fwd_hs: cover property (fwd_valid && !fwd_ready ##1 fwd_valid && fwd_ready);
   c_pause: cover property (pause_valid);
   c_age_drop: cover property (s_reg.st == ST_IDLE && !frm_valid && cfg.aging_en &&
      is_stale(s_reg.table_e[s_reg.age_ptr], s_reg.now));
   c_migrate: cover property (s_reg.st == ST_DECIDE && s_reg.sa_hit &&
      s_reg.table_e[s_reg.sa_idx].port != s_reg.frm.ingress);
endmodule

// ===== sim/swl_mac_model.sv
module swl_mac_model (
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   input  wire logic              fwd_valid,
   input  wire swl_pkg::swl_fwd_s fwd,
   input  wire logic [3:0]        wait_cyc,
   output logic                   fwd_ready,
   output logic                   rel_valid,
   output logic [9:0]             rel_count
);
   timeunit 1ns;
   timeprecision 1ps;
   import swl_pkg::*;

   logic [3:0] wait_reg;

   // Egress stalls for the commanded number of cycles before it accepts
   assign fwd_ready = fwd_valid && (wait_reg >= wait_cyc);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wait_reg  <= 4'h0;
         rel_valid <= 1'b0;
         rel_count <= 10'h0;
      end else begin
         wait_reg  <= (fwd_valid && !fwd_ready) ? wait_reg + 4'h1 : 4'h0;
         // Frame drains at once, so its buffers go back to the pool
         rel_valid <= fwd_valid && fwd_ready;
         rel_count <= (fwd_valid && fwd_ready) ? fwd.bufs : 10'h0;
      end
   end
endmodule

// ===== sim/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import swl_pkg::*;

   localparam swl_mac_t mac_a = 48'h0000_1000_00a1;
   localparam swl_mac_t mac_b = 48'h0000_1000_00b2;
   localparam swl_mac_t mac_c = 48'h0000_1000_00c3;
   localparam swl_mac_t mac_d = 48'h0000_1000_00d4;
   localparam swl_mac_t mac_e = 48'h0000_1000_00e5;
   localparam swl_mac_t mac_f = 48'h0000_1000_00f6;
   localparam swl_mac_t mac_g = 48'h0000_1000_0017;

   logic        clk_sys;
   logic        rst_n;
   swl_cfg_s    cfg;
   logic        frm_valid;
   logic        frm_ready;
   swl_frame_s  frm;
   logic        fwd_valid;
   logic        fwd_ready;
   swl_fwd_s    fwd;
   logic        pause_valid;
   swl_pause_s  pause;
   logic        rel_valid;
   logic [9:0]  rel_count;
   logic [3:0]  wait_cyc;
   int          err_total;
   int          n_tests;

   swl_core #(.AGE_TICK_CYC(36'd2000)) u_swl_core (
      .clk_sys     (clk_sys),
      .rst_n       (rst_n),
      .cfg         (cfg),
      .frm_valid   (frm_valid),
      .frm_ready   (frm_ready),
      .frm         (frm),
      .fwd_valid   (fwd_valid),
      .fwd_ready   (fwd_ready),
      .fwd         (fwd),
      .pause_valid (pause_valid),
      .pause       (pause),
      .rel_valid   (rel_valid),
      .rel_count   (rel_count)
   );

   swl_mac_model u_swl_mac_model (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .fwd_valid (fwd_valid),
      .fwd       (fwd),
      .wait_cyc  (wait_cyc),
      .fwd_ready (fwd_ready),
      .rel_valid (rel_valid),
      .rel_count (rel_count)
   );

   always #5 clk_sys = ~clk_sys;

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk_flag(input string nm, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %b seen %b", nm, exp, got);
      end
   endtask

   task automatic chk_val(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   function automatic swl_frame_s mk(input swl_port_t p, input swl_mac_t da,
                                     input swl_mac_t sa, input logic [11:0] len);
      swl_frame_s f;
      f = '0;
      f.ingress = p;
      f.destination_station_address = da;
      f.source_station_address = sa;
      f.len = len;
      return f;
   endfunction

   // Offers one descriptor and judges forward and pause outcome
   task automatic send(input swl_frame_s f, input logic ef, input swl_mask_t em,
                       input logic [9:0] eb, input logic ep);
      logic       gf;
      logic       gp;
      logic       done;
      swl_fwd_s   gfw;
      swl_pause_s gps;
      gf = 1'b0;
      gp = 1'b0;
      done = 1'b0;
      gfw = '0;
      gps = '0;
      @(posedge clk_sys);
      frm       <= f;
      frm_valid <= 1'b1;
      @(posedge clk_sys);
      frm_valid <= 1'b0;
      for (int n = 0; n < 1300 && !done; n++) begin
         @(posedge clk_sys);
         #1;
         if (fwd_valid === 1'b1 && fwd_ready === 1'b1) begin
            gf = 1'b1;
            gfw = fwd;
         end
         if (pause_valid === 1'b1) begin
            gp = 1'b1;
            gps = pause;
         end
         done = (frm_ready === 1'b1) && (n > 2);
      end
      chk_flag("completed", 1'b1, done);
      chk_flag("forwarded", ef, gf);
      if (ef) begin
         chk_val("port mask", {11'h0, em}, {11'h0, gfw.final_port_mask});
         chk_val("buffers", {6'h0, eb}, {6'h0, gfw.bufs});
         chk_val("fwd ingress", {13'h0, f.ingress}, {13'h0, gfw.ingress});
      end
      chk_flag("pause", ep, gp);
      if (ep) begin
         chk_val("pause port", {13'h0, f.ingress}, {13'h0, gps.port});
         chk_val("quanta", f.pause_quanta, gps.quanta);
      end
   endtask

   task automatic t_learn;
      send(mk(3'd1, mac_b, mac_a, 12'd64), 1'b1, 5'h1d, 10'd1, 1'b0);
      wait_cyc <= 4'd3;
      send(mk(3'd2, mac_a, mac_b, 12'd1536), 1'b1, 5'h02, 10'd12, 1'b0);
      wait_cyc <= 4'd0;
      send(mk(3'd1, mac_a, mac_a, 12'd64), 1'b0, 5'h00, 10'd0, 1'b0);
   endtask

   task automatic t_migrate;
      send(mk(3'd3, mac_b, mac_a, 12'd129), 1'b1, 5'h04, 10'd2, 1'b0);
      send(mk(3'd2, mac_a, mac_b, 12'd64), 1'b1, 5'h08, 10'd1, 1'b0);
   endtask

   task automatic t_bad;
      swl_frame_s f;
      for (int k = 0; k < 5; k++) begin
         f = mk(3'd4, mac_a, mac_c, (k == 0) ? 12'd63 : (k == 1) ? 12'd1537 : 12'd100);
         f.err_fcs = (k == 2);
         f.err_framing = (k == 3);
         f.err_align = (k == 4);
         send(f, 1'b0, 5'h00, 10'd0, 1'b0);
      end
      send(mk(3'd0, mac_c, mac_d, 12'd64), 1'b1, 5'h1e, 10'd1, 1'b0);
   endtask

   task automatic t_pause;
      swl_frame_s f;
      f = mk(3'd0, mac_b, mac_e, 12'd64);
      f.is_pause = 1'b1;
      f.pause_quanta = 16'h1234;
      send(f, 1'b0, 5'h00, 10'd0, 1'b1);
      send(mk(3'd1, mac_e, mac_d, 12'd64), 1'b1, 5'h1d, 10'd1, 1'b0);
   endtask

   task automatic t_acl;
      swl_frame_s f;
      f = mk(3'd2, mac_a, mac_b, 12'd64);
      f.access_list_hit = 1'b1;
      f.access_list_filter = 5'h11;
      send(f, 1'b1, 5'h11, 10'd1, 1'b0);
      cfg.auth_mask <= 5'h1b;
      send(f, 1'b0, 5'h00, 10'd0, 1'b0);
      cfg.auth_mask <= 5'h1f;
   endtask

   task automatic t_stage2;
      swl_frame_s f;
      cfg.stp_fwd_mask <= 5'h17;
      send(mk(3'd0, mac_f, mac_d, 12'd64), 1'b1, 5'h16, 10'd1, 1'b0);
      cfg.stp_fwd_mask <= 5'h1f;
      cfg.vlan_mask[5] <= 5'h07;
      f = mk(3'd0, mac_f, mac_d, 12'd64);
      f.vid = 12'd5;
      send(f, 1'b1, 5'h06, 10'd1, 1'b0);
      f = mk(3'd0, mac_f, mac_d, 12'd64);
      f.is_igmp = 1'b1;
      send(f, 1'b1, 5'h10, 10'd1, 1'b0);
      cfg.static_tab[0] <= {1'b1, mac_g, 5'h18};
      send(mk(3'd0, mac_g, mac_d, 12'd64), 1'b1, 5'h18, 10'd1, 1'b0);
      cfg.mirror_en <= 1'b1;
      cfg.mirror_port <= 3'd1;
      cfg.mirror_rx_mask <= 5'h01;
      send(mk(3'd0, mac_a, mac_d, 12'd64), 1'b1, 5'h0a, 10'd1, 1'b0);
      cfg.mirror_en <= 1'b0;
   endtask

   task automatic t_aging;
      repeat (12000) @(posedge clk_sys);
      send(mk(3'd0, mac_a, mac_d, 12'd64), 1'b1, 5'h08, 10'd1, 1'b0);
      cfg.aging_en <= 1'b1;
      repeat (12000) @(posedge clk_sys);
      send(mk(3'd0, mac_a, mac_d, 12'd64), 1'b1, 5'h1e, 10'd1, 1'b0);
   endtask

   initial begin
      clk_sys = 1'b0;
      rst_n = 1'b0;
      cfg = '0;
      cfg.stp_fwd_mask = 5'h1f;
      cfg.auth_mask = 5'h1f;
      cfg.host_port = 3'd4;
      for (int k = 0; k < 16; k++) begin
         cfg.vlan_mask[k] = 5'h1f;
      end
      frm_valid = 1'b0;
      frm = '0;
      wait_cyc = 4'd0;
      err_total = 0;
      n_tests = 0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(negedge clk_sys);
      chk_flag("ready after reset", 1'b1, frm_ready);
      chk_flag("fwd after reset", 1'b0, fwd_valid);
      chk_flag("pause after reset", 1'b0, pause_valid);
      t_learn;
      t_migrate;
      t_bad;
      t_pause;
      t_acl;
      t_stage2;
      t_aging;
      tally_and_finish;
   end

   // Longest expected run is about 50000 cycles
   initial begin
      repeat (70000) @(posedge clk_sys);
      err_total++;
      tally_and_finish;
   end
endmodule
